//--- cmbd_pkg.sv
/*
  shared types and constants for the move, branch and bit instruction decoder.
  assumes a single core clock and one program-memory byte stream feeding the decoder.
*/
package cmbd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and field positions
  localparam int unsigned CMBD_BYTE_W = 8;
  localparam int unsigned CMBD_LEN_W = 2;
  localparam int unsigned CMBD_CYC_W = 4;
  localparam int unsigned CMBD_PAGE_W = 11;
  // program-memory-write select inside the power control byte
  localparam int unsigned CMBD_PWR_PMW_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // timing counts, in core clock cycles
  // external-ram moves stretch from 3 to 10 (read) or 4 to 11 (write) cycles
  localparam logic [CMBD_CYC_W-1:0] CMBD_XRAM_WAIT_MAX = 4'h7;
  localparam logic [CMBD_CYC_W-1:0] CMBD_ONE_CYCLE = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic CMBD_READY_RESET = 1'b1;
  localparam logic [CMBD_BYTE_W-1:0] CMBD_BYTE_RESET = 8'h00;
  localparam logic [CMBD_CYC_W-1:0] CMBD_CYC_RESET = 4'h0;
  localparam logic [CMBD_LEN_W-1:0] CMBD_LEN_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // instruction kinds handed to the execution side
  typedef enum logic [4:0] {
    OP_FOREIGN             = 5'b00000, // arithmetic or logic group, decoded elsewhere
    OP_NOP                 = 5'b00001,
    OP_MOVE_TO_ACC         = 5'b00010,
    OP_MOVE_TO_REG         = 5'b00011,
    OP_MOVE_TO_DIRECT      = 5'b00100,
    OP_MOVE_TO_INDIRECT    = 5'b00101,
    OP_LOAD_DATA_POINTER   = 5'b00110,
    OP_CODE_BYTE_LOAD      = 5'b00111,
    OP_XRAM_READ           = 5'b01000,
    OP_XRAM_WRITE          = 5'b01001,
    OP_PUSH                = 5'b01010,
    OP_POP                 = 5'b01011,
    OP_EXCHANGE            = 5'b01100,
    OP_LOW_NIBBLE_EXCHANGE = 5'b01101,
    OP_ABSOLUTE_CALL       = 5'b01110,
    OP_LONG_CALL           = 5'b01111,
    OP_RETURN              = 5'b10000,
    OP_INTERRUPT_RETURN    = 5'b10001,
    OP_ABSOLUTE_JUMP       = 5'b10010,
    OP_LONG_JUMP           = 5'b10011,
    OP_SHORT_RELATIVE_JUMP = 5'b10100,
    OP_JUMP_INDEXED        = 5'b10101,
    OP_ACC_BRANCH          = 5'b10110,
    OP_CARRY_BRANCH        = 5'b10111,
    OP_BIT_BRANCH          = 5'b11000,
    OP_BIT_TEST_JUMP_CLEAR = 5'b11001,
    OP_COMPARE_BRANCH      = 5'b11010,
    OP_DECREMENT_BRANCH    = 5'b11011,
    OP_CARRY_BIT_OP        = 5'b11100,
    OP_DIRECT_BIT_OP       = 5'b11101,
    OP_CARRY_LOGIC         = 5'b11110,
    OP_BIT_MOVE            = 5'b11111
  } cmbd_op_type;

  // static decode of one opcode
  typedef struct packed {
    cmbd_op_type op;
    logic [CMBD_LEN_W-1:0] length;
    logic [CMBD_CYC_W-1:0] cycles;
  } cmbd_info_type;

  // completed instruction as handed out at retirement
  typedef struct packed {
    cmbd_op_type op;
    logic [CMBD_BYTE_W-1:0] opcode;
    logic [CMBD_BYTE_W-1:0] operand1;
    logic [CMBD_BYTE_W-1:0] operand2;
    logic [CMBD_LEN_W-1:0] length;
    logic [CMBD_CYC_W-1:0] cycles;
    logic [CMBD_PAGE_W-1:0] page_addr;
    logic code_space;
  } cmbd_instr_type;

endpackage

//--- cmbd_cycle_timer.sv
/*
  per-instruction cycle counter: loads the documented count at the opcode
  and counts it down one core cycle at a time.
  assumes start only while idle; stall and hold freeze the count.
*/
`timescale 1ns/1ps
module cmbd_cycle_timer
  import cmbd_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic reset_i, // async reset, active high
  input wire logic start_i, // opcode taken this cycle
  input wire logic [CMBD_CYC_W-1:0] count_i, // documented cycle count
  input wire logic stall_i, // operand byte missing
  input wire logic hold_i, // wait state from memory interface
  output logic active_o, // an instruction is in flight
  output logic [CMBD_CYC_W-1:0] remain_o, // cycles still to run
  output logic finish_o // last cycle of the instruction
);

  logic [CMBD_CYC_W-1:0] remain_q;
  logic [CMBD_CYC_W-1:0] remain_d;
  logic step_w;

  // count down unless frozen
  assign active_o = (remain_q != CMBD_CYC_RESET);
  assign remain_o = remain_q;
  assign step_w = active_o & ~stall_i & ~hold_i;
  assign finish_o = (start_i & (count_i == CMBD_ONE_CYCLE))
                  | (step_w & (remain_q == CMBD_ONE_CYCLE));
  assign remain_d = start_i ? (count_i - CMBD_ONE_CYCLE)
                  : (step_w ? (remain_q - CMBD_ONE_CYCLE) : remain_q);

  // counter register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      remain_q <= CMBD_CYC_RESET;
    end else begin
      remain_q <= remain_d;
    end
  end

endmodule // cmbd_cycle_timer

//--- cmbd_operand_capture.sv
/*
  collects the operand bytes that follow an opcode.
  assumes take only while bytes are still owed; start sets the count owed.
*/
`timescale 1ns/1ps
module cmbd_operand_capture
  import cmbd_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic reset_i, // async reset, active high
  input wire logic start_i, // opcode taken this cycle
  input wire logic [CMBD_LEN_W-1:0] length_i, // byte length of new opcode
  input wire logic take_i, // operand byte taken this cycle
  input wire logic [CMBD_BYTE_W-1:0] byte_i, // program memory byte
  output logic pending_o, // operand bytes still owed
  output logic [CMBD_LEN_W-1:0] need_next_o, // bytes owed after this edge
  output logic [CMBD_BYTE_W-1:0] operand1_o, // first operand, next value
  output logic [CMBD_BYTE_W-1:0] operand2_o // second operand, next value
);

  logic [CMBD_LEN_W-1:0] need_q;
  logic slot_q;
  logic [CMBD_BYTE_W-1:0] op1_q;
  logic [CMBD_BYTE_W-1:0] op2_q;

  // next values, visible in the cycle the byte arrives
  assign pending_o = (need_q != CMBD_LEN_RESET);
  assign need_next_o = start_i ? (length_i - 2'h1) : (take_i ? (need_q - 2'h1) : need_q);
  assign operand1_o = start_i ? CMBD_BYTE_RESET : ((take_i & ~slot_q) ? byte_i : op1_q);
  assign operand2_o = start_i ? CMBD_BYTE_RESET : ((take_i & slot_q) ? byte_i : op2_q);

  // operand registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      need_q <= CMBD_LEN_RESET;
      slot_q <= 1'b0;
      op1_q <= CMBD_BYTE_RESET;
      op2_q <= CMBD_BYTE_RESET;
    end else begin
      need_q <= need_next_o;
      slot_q <= start_i ? 1'b0 : (slot_q | take_i);
      op1_q <= operand1_o;
      op2_q <= operand2_o;
    end
  end

endmodule // cmbd_operand_capture

//--- cmbd_decoder.sv
/*
  decode and cycle timing for the data transfer, program branch and boolean
  instruction groups of the 8-bit core.
  assumes program memory offers one byte per cycle with valid/ready, and the
  external-ram interface reports completion on the core clock.
*/
`timescale 1ns/1ps
module cmbd_decoder
  import cmbd_pkg::*;
(
  input wire logic clk_i, // core clock, 50 MHz
  input wire logic reset_i, // async reset, active high
  input wire logic [CMBD_BYTE_W-1:0] code_byte_i, // program memory byte
  input wire logic code_valid_i, // byte on code_byte_i is valid
  output logic code_ready_o, // decoder takes a byte this cycle
  input wire logic [CMBD_BYTE_W-1:0] power_ctrl_i, // power control byte
  input wire logic xram_done_i, // external-ram access complete
  output logic xram_req_o, // external-ram move in flight
  output logic xram_code_sel_o, // move targets program memory
  output logic busy_o, // multi-cycle instruction in flight
  output logic retire_o, // instruction complete, one-cycle pulse
  output cmbd_instr_type instr_o // last retired instruction
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  cmbd_info_type info_w;
  logic code_ready_q;
  logic accept_w;
  logic take_w;
  logic stall_w;
  logic hold_w;
  logic active_w;
  logic finish_w;
  logic pending_w;

  // handshake and sequencing
  logic busy_d;
  logic ready_d;
  logic xram_w;

  // submodule results
  logic [CMBD_CYC_W-1:0] remain_w;
  logic [CMBD_LEN_W-1:0] need_next_w;
  logic [CMBD_BYTE_W-1:0] operand1_w;
  logic [CMBD_BYTE_W-1:0] operand2_w;

  // opcode latch and outputs
  cmbd_op_type op_q;
  logic [CMBD_BYTE_W-1:0] opcode_q;
  logic [CMBD_LEN_W-1:0] length_q;
  logic [CMBD_CYC_W-1:0] cycles_q;
  logic [CMBD_CYC_W-1:0] waits_q;
  logic [CMBD_CYC_W-1:0] waits_d;
  logic xram_q;
  logic code_sel_q;
  logic busy_q;
  logic retire_q;
  cmbd_instr_type instr_q;
  cmbd_instr_type instr_d;

  // retire sources
  cmbd_op_type op_src_w;
  logic [CMBD_BYTE_W-1:0] opcode_src_w;
  logic [CMBD_LEN_W-1:0] length_src_w;
  logic [CMBD_CYC_W-1:0] cycles_src_w;
  logic code_sel_src_w;
  logic pmw_w;

  ////////////////////////////////////////////////////////////////////////////
  // static opcode table
  function automatic cmbd_info_type mk(
    input cmbd_op_type op,
    input logic [CMBD_LEN_W-1:0] len,
    input logic [CMBD_CYC_W-1:0] cyc
  );
    cmbd_info_type r;
    r.op = op;
    r.length = len;
    r.cycles = cyc;
    return r;
  endfunction

  // opcode to kind, byte length and cycle count; legacy encodings kept
  always_comb begin
    casez (code_byte_i)
      8'b1110_1???: info_w = mk(OP_MOVE_TO_ACC, 2'h1, 4'h1);
      8'he5: info_w = mk(OP_MOVE_TO_ACC, 2'h2, 4'h2);
      8'b1110_011?: info_w = mk(OP_MOVE_TO_ACC, 2'h1, 4'h2);
      8'h74: info_w = mk(OP_MOVE_TO_ACC, 2'h2, 4'h2);
      8'b1111_1???: info_w = mk(OP_MOVE_TO_REG, 2'h1, 4'h2);
      8'b1010_1???: info_w = mk(OP_MOVE_TO_REG, 2'h2, 4'h4);
      8'b0111_1???: info_w = mk(OP_MOVE_TO_REG, 2'h2, 4'h2);
      8'hf5: info_w = mk(OP_MOVE_TO_DIRECT, 2'h2, 4'h3);
      8'b1000_1???: info_w = mk(OP_MOVE_TO_DIRECT, 2'h2, 4'h3);
      8'h85: info_w = mk(OP_MOVE_TO_DIRECT, 2'h3, 4'h4);
      8'b1000_011?: info_w = mk(OP_MOVE_TO_DIRECT, 2'h2, 4'h4);
      8'h75: info_w = mk(OP_MOVE_TO_DIRECT, 2'h3, 4'h3);
      8'b1111_011?: info_w = mk(OP_MOVE_TO_INDIRECT, 2'h1, 4'h3);
      8'b1010_011?: info_w = mk(OP_MOVE_TO_INDIRECT, 2'h2, 4'h5);
      8'b0111_011?: info_w = mk(OP_MOVE_TO_INDIRECT, 2'h2, 4'h3);

      // pointer and code bytes
      8'h90: info_w = mk(OP_LOAD_DATA_POINTER, 2'h3, 4'h3);
      8'h93: info_w = mk(OP_CODE_BYTE_LOAD, 2'h1, 4'h3);
      8'h83: info_w = mk(OP_CODE_BYTE_LOAD, 2'h1, 4'h3);

      // external-ram moves
      8'b1110_001?: info_w = mk(OP_XRAM_READ, 2'h1, 4'h3);
      8'he0: info_w = mk(OP_XRAM_READ, 2'h1, 4'h3);
      8'b1111_001?: info_w = mk(OP_XRAM_WRITE, 2'h1, 4'h4);
      8'hf0: info_w = mk(OP_XRAM_WRITE, 2'h1, 4'h4);

      8'hc0: info_w = mk(OP_PUSH, 2'h2, 4'h4);
      8'hd0: info_w = mk(OP_POP, 2'h2, 4'h3);
      8'b1100_1???: info_w = mk(OP_EXCHANGE, 2'h1, 4'h2);
      8'hc5: info_w = mk(OP_EXCHANGE, 2'h2, 4'h3);
      8'b1100_011?: info_w = mk(OP_EXCHANGE, 2'h1, 4'h3);
      8'b1101_011?: info_w = mk(OP_LOW_NIBBLE_EXCHANGE, 2'h1, 4'h3);

      // calls and returns
      8'b???1_0001: info_w = mk(OP_ABSOLUTE_CALL, 2'h2, 4'h6);
      8'h12: info_w = mk(OP_LONG_CALL, 2'h3, 4'h6);
      8'h22: info_w = mk(OP_RETURN, 2'h1, 4'h4);
      8'h32: info_w = mk(OP_INTERRUPT_RETURN, 2'h1, 4'h4);

      8'b???0_0001: info_w = mk(OP_ABSOLUTE_JUMP, 2'h2, 4'h3);
      8'h02: info_w = mk(OP_LONG_JUMP, 2'h3, 4'h4);
      8'h80: info_w = mk(OP_SHORT_RELATIVE_JUMP, 2'h2, 4'h3);
      8'h73: info_w = mk(OP_JUMP_INDEXED, 2'h1, 4'h2);

      // conditional branches
      8'h60, 8'h70: info_w = mk(OP_ACC_BRANCH, 2'h2, 4'h3);
      8'h40, 8'h50: info_w = mk(OP_CARRY_BRANCH, 2'h2, 4'h3);
      8'h20, 8'h30: info_w = mk(OP_BIT_BRANCH, 2'h3, 4'h4);
      8'h10: info_w = mk(OP_BIT_TEST_JUMP_CLEAR, 2'h3, 4'h4);
      8'hb4, 8'hb5: info_w = mk(OP_COMPARE_BRANCH, 2'h3, 4'h4);
      8'b1011_011?: info_w = mk(OP_COMPARE_BRANCH, 2'h3, 4'h4);
      8'b1011_1???: info_w = mk(OP_COMPARE_BRANCH, 2'h3, 4'h4);
      8'b1101_1???: info_w = mk(OP_DECREMENT_BRANCH, 2'h2, 4'h3);
      8'hd5: info_w = mk(OP_DECREMENT_BRANCH, 2'h3, 4'h4);

      // bits
      8'hc3, 8'hd3, 8'hb3: info_w = mk(OP_CARRY_BIT_OP, 2'h1, 4'h1);
      8'hc2, 8'hd2, 8'hb2: info_w = mk(OP_DIRECT_BIT_OP, 2'h2, 4'h3);
      8'h82, 8'hb0, 8'h72, 8'ha0: info_w = mk(OP_CARRY_LOGIC, 2'h2, 4'h2);
      8'ha2: info_w = mk(OP_BIT_MOVE, 2'h2, 4'h2);
      8'h92: info_w = mk(OP_BIT_MOVE, 2'h2, 4'h3);

      8'h00: info_w = mk(OP_NOP, 2'h1, 4'h1);
      default: info_w = mk(OP_FOREIGN, 2'h1, 4'h1);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte handshake and sequencing terms
  assign accept_w = code_ready_q & code_valid_i & ~active_w;
  assign take_w = code_ready_q & code_valid_i & pending_w;
  assign stall_w = pending_w & ~take_w;
  assign xram_w = (info_w.op == OP_XRAM_READ) | (info_w.op == OP_XRAM_WRITE);
  assign pmw_w = power_ctrl_i[CMBD_PWR_PMW_BIT];

  // stretch the last base cycle until the memory interface finishes or CMBD_XRAM_WAIT_MAX waits have run
  assign hold_w = xram_q & (remain_w == CMBD_ONE_CYCLE) & ~xram_done_i
                & (waits_q != CMBD_XRAM_WAIT_MAX);
  // cleared at retire too, so a following short opcode reports no waits
  assign waits_d = (accept_w | finish_w) ? CMBD_CYC_RESET
                 : (hold_w ? (waits_q + CMBD_ONE_CYCLE) : waits_q);

  // next-cycle busy and ready; back-to-back opcodes when finishing
  assign busy_d = (accept_w | active_w) & ~finish_w;
  assign ready_d = ~busy_d | (need_next_w != CMBD_LEN_RESET);

  ////////////////////////////////////////////////////////////////////////////
  // cycle count, one core cycle per step
  cmbd_cycle_timer u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(accept_w),
    .count_i(info_w.cycles),
    .stall_i(stall_w),
    .hold_i(hold_w),
    .active_o(active_w),
    .remain_o(remain_w),
    .finish_o(finish_w)
  );

  // operand bytes after the opcode
  cmbd_operand_capture u_operands (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(accept_w),
    .length_i(info_w.length),
    .take_i(take_w),
    .byte_i(code_byte_i),
    .pending_o(pending_w),
    .need_next_o(need_next_w),
    .operand1_o(operand1_w),
    .operand2_o(operand2_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // retired instruction; a one-cycle opcode retires on its own edge
  assign op_src_w = accept_w ? info_w.op : op_q;
  assign opcode_src_w = accept_w ? code_byte_i : opcode_q;
  assign length_src_w = accept_w ? info_w.length : length_q;
  assign cycles_src_w = accept_w ? info_w.cycles : cycles_q;
  assign code_sel_src_w = accept_w ? (xram_w & pmw_w) : code_sel_q;

  always_comb begin
    instr_d = instr_q;
    if (finish_w) begin
      instr_d.op = op_src_w;
      instr_d.opcode = opcode_src_w;
      instr_d.operand1 = operand1_w;
      instr_d.operand2 = operand2_w;
      instr_d.length = length_src_w;
      instr_d.cycles = cycles_src_w + waits_q;
      instr_d.page_addr = {opcode_src_w[7:5], operand1_w};
      instr_d.code_space = code_sel_src_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // opcode latch, held while the instruction runs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      op_q <= OP_NOP;
      opcode_q <= CMBD_BYTE_RESET;
      length_q <= CMBD_LEN_RESET;
      cycles_q <= CMBD_CYC_RESET;
      xram_q <= 1'b0;
      code_sel_q <= 1'b0;
    end else if (accept_w) begin
      op_q <= info_w.op;
      opcode_q <= code_byte_i;
      length_q <= info_w.length;
      cycles_q <= info_w.cycles;
      xram_q <= xram_w;
      code_sel_q <= xram_w & pmw_w;
    end
  end

  // handshake, wait states and outputs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      code_ready_q <= CMBD_READY_RESET;
      waits_q <= CMBD_CYC_RESET;
      busy_q <= 1'b0;
      retire_q <= 1'b0;
      instr_q <= '0;
    end else begin
      code_ready_q <= ready_d;
      waits_q <= waits_d;
      busy_q <= busy_d;
      retire_q <= finish_w;
      instr_q <= instr_d;
    end
  end

  // external-ram request stands until the move completes
  logic xram_req_q;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      xram_req_q <= 1'b0;
    end else begin
      xram_req_q <= (accept_w & xram_w) | (xram_req_q & ~finish_w);
    end
  end

  assign code_ready_o = code_ready_q;
  assign xram_req_o = xram_req_q;
  assign xram_code_sel_o = code_sel_q;
  assign busy_o = busy_q;
  assign retire_o = retire_q;
  assign instr_o = instr_q;

endmodule // cmbd_decoder

//--- cmbd_decoder_properties.sv
/*
  concurrent checks on the decoder's ports: decode, timing and external-ram hand-off.
  assumes a single core clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
module cmbd_decoder_checker
  import cmbd_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic reset_i, // async reset, active high
  input wire logic [CMBD_BYTE_W-1:0] code_byte_i, // program memory byte
  input wire logic code_valid_i, // byte valid
  input wire logic code_ready_o, // decoder takes a byte
  input wire logic [CMBD_BYTE_W-1:0] power_ctrl_i, // power control byte
  input wire logic xram_done_i, // external-ram access complete
  input wire logic xram_req_o, // external-ram move in flight
  input wire logic xram_code_sel_o, // move targets program memory
  input wire logic busy_o, // instruction in flight
  input wire logic retire_o, // instruction complete
  input wire cmbd_instr_type instr_o // last retired instruction
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////////////
  // decode and timing of retired instructions
  a_instr_stands: assert property (
    !retire_o |-> $stable(instr_o)) else $error("instr changed without retire");
  a_reg_to_acc: assert property (
    retire_o && instr_o.opcode[7:3] == 5'b11101 |-> instr_o.op == OP_MOVE_TO_ACC
    && instr_o.length == 2'h1 && instr_o.cycles == 4'h1) else $error("reg to acc wrong");
  a_long_call_gap: assert property (
    retire_o && instr_o.op == OP_LONG_CALL |-> !$past(code_ready_o)
    && !$past(code_ready_o, 3) && instr_o.cycles == 4'h6) else $error("long call timing");
  a_page_addr: assert property (
    retire_o && (instr_o.op == OP_ABSOLUTE_CALL || instr_o.op == OP_ABSOLUTE_JUMP)
    |-> instr_o.page_addr == {instr_o.opcode[7:5], instr_o.operand1})
    else $error("page address wrong");
  a_ready_at_retire: assert property (
    retire_o |-> code_ready_o) else $error("ready low at retire");

  ////////////////////////////////////////////////////////////////////////////
  // external-ram moves
  a_xram_select: assert property (
    $rose(xram_req_o) |-> xram_code_sel_o == $past(power_ctrl_i[CMBD_PWR_PMW_BIT]))
    else $error("pmw select not captured");
  a_xram_read_span: assert property (
    retire_o && instr_o.op == OP_XRAM_READ |-> instr_o.cycles >= 4'h3
    && instr_o.cycles <= 4'ha) else $error("read cycles out of range");
  a_xram_write_span: assert property (
    retire_o && instr_o.op == OP_XRAM_WRITE |-> instr_o.cycles >= 4'h4
    && instr_o.cycles <= 4'hb) else $error("write cycles out of range");
  a_xram_req_end: assert property (
    $fell(xram_req_o) |-> retire_o) else $error("request dropped without retire");
  a_xram_busy: assert property (
    xram_req_o |-> busy_o) else $error("request without busy");
endmodule // cmbd_decoder_checker

bind cmbd_decoder cmbd_decoder_checker u_checker (.clk_i(clk_i), .reset_i(reset_i),
  .code_byte_i(code_byte_i), .code_valid_i(code_valid_i), .code_ready_o(code_ready_o),
  .power_ctrl_i(power_ctrl_i), .xram_done_i(xram_done_i), .xram_req_o(xram_req_o),
  .xram_code_sel_o(xram_code_sel_o), .busy_o(busy_o), .retire_o(retire_o),
  .instr_o(instr_o));

//--- cmbd_code_rom.sv
/*
  program-memory model offering one byte per cycle with valid/ready.
  assumes the bench queues bytes and gap markers through put().
*/
`timescale 1ns/1ps
module cmbd_code_rom
  import cmbd_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic reset_i, // async reset, active high
  input wire logic code_ready_i, // decoder takes the byte
  output logic [CMBD_BYTE_W-1:0] code_byte_o, // offered byte
  output logic code_valid_o // offered byte is valid
);
  logic [8:0] fifo_q[$]; // bit 8 set marks a gap of n cycles
  int gap = 0;

  initial begin
    code_byte_o = 8'h00;
    code_valid_o = 1'b0;
  end

  // queue one byte or gap marker
  task automatic put(input logic [8:0] item);
    fifo_q.push_back(item);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // drop the byte taken at this edge, then offer the next
  always @(posedge clk_i) begin
    if (code_valid_o && code_ready_i && !reset_i) begin
      void'(fifo_q.pop_front());
    end
    #1;
    if (gap == 0 && fifo_q.size() > 0 && fifo_q[0][8]) begin
      gap = fifo_q[0][7:0];
      void'(fifo_q.pop_front());
    end
    if (gap > 0 || fifo_q.size() == 0) begin
      gap = gap > 0 ? gap - 1 : 0;
      code_valid_o = 1'b0;
      code_byte_o = ~code_byte_o; // no stale byte while idle
    end else begin
      code_valid_o = 1'b1;
      code_byte_o = fifo_q[0][7:0];
    end
  end
endmodule // cmbd_code_rom

//--- cmbd_decoder_bench.sv
/*
  self-checking bench for the decoder: opcode table, operand stall,
  external-ram waits and reset in mid-instruction.
  assumes the program-memory model and the bound checker.
*/
`timescale 1ns/1ps
module cmbd_decoder_bench
  import cmbd_pkg::*;
;
  logic clk;
  logic reset;
  logic [7:0] power_ctrl;
  logic xram_done;
  logic [7:0] code_byte;
  logic code_valid, code_ready, xram_req, xram_sel, busy, retire;
  cmbd_instr_type instr;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int xc = 0;
  int tgt = 100;
  cmbd_instr_type rq[$];
  int rt[$];

  cmbd_decoder dut (.clk_i(clk), .reset_i(reset), .code_byte_i(code_byte),
    .code_valid_i(code_valid), .code_ready_o(code_ready), .power_ctrl_i(power_ctrl),
    .xram_done_i(xram_done), .xram_req_o(xram_req), .xram_code_sel_o(xram_sel),
    .busy_o(busy), .retire_o(retire), .instr_o(instr));
  cmbd_code_rom rom (.clk_i(clk), .reset_i(reset), .code_ready_i(code_ready),
    .code_byte_o(code_byte), .code_valid_o(code_valid));

  ////////////////////////////////////////////////////////////////////////////
  // clock, timeout, retire monitor, external-ram completion
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      failures++;
      complete_run();
    end
  end
  always @(negedge clk) if (retire === 1'b1) begin
    rq.push_back(instr);
    rt.push_back(cyc);
  end
  always @(posedge clk) begin
    xc = xram_req ? xc + 1 : 0;
    #1 xram_done = (xc >= tgt);
  end

  ////////////////////////////////////////////////////////////////////////////
  // expected decode of one opcode
  function automatic cmbd_info_type exp_of(input logic [7:0] opc);
    case (opc)
      8'he8, 8'hef: exp_of = '{OP_MOVE_TO_ACC, 2'h1, 4'h1};
      8'he5, 8'h74: exp_of = '{OP_MOVE_TO_ACC, 2'h2, 4'h2};
      8'h7f: exp_of = '{OP_MOVE_TO_REG, 2'h2, 4'h2};
      8'hf8: exp_of = '{OP_MOVE_TO_REG, 2'h1, 4'h2};
      8'hf5, 8'h88: exp_of = '{OP_MOVE_TO_DIRECT, 2'h2, 4'h3};
      8'h85: exp_of = '{OP_MOVE_TO_DIRECT, 2'h3, 4'h4};
      8'h90: exp_of = '{OP_LOAD_DATA_POINTER, 2'h3, 4'h3};
      8'h93, 8'h83: exp_of = '{OP_CODE_BYTE_LOAD, 2'h1, 4'h3};
      8'he0, 8'he2, 8'he3: exp_of = '{OP_XRAM_READ, 2'h1, 4'h3};
      8'hf0, 8'hf2, 8'hf3: exp_of = '{OP_XRAM_WRITE, 2'h1, 4'h4};
      8'hc6: exp_of = '{OP_EXCHANGE, 2'h1, 4'h3};
      8'hd7: exp_of = '{OP_LOW_NIBBLE_EXCHANGE, 2'h1, 4'h3};
      8'h11, 8'hf1: exp_of = '{OP_ABSOLUTE_CALL, 2'h2, 4'h6};
      8'h12: exp_of = '{OP_LONG_CALL, 2'h3, 4'h6};
      8'h22: exp_of = '{OP_RETURN, 2'h1, 4'h4};
      8'h32: exp_of = '{OP_INTERRUPT_RETURN, 2'h1, 4'h4};
      8'he1: exp_of = '{OP_ABSOLUTE_JUMP, 2'h2, 4'h3};
      8'h02: exp_of = '{OP_LONG_JUMP, 2'h3, 4'h4};
      8'h80: exp_of = '{OP_SHORT_RELATIVE_JUMP, 2'h2, 4'h3};
      8'h73: exp_of = '{OP_JUMP_INDEXED, 2'h1, 4'h2};
      8'h60, 8'h70: exp_of = '{OP_ACC_BRANCH, 2'h2, 4'h3};
      8'h40, 8'h50: exp_of = '{OP_CARRY_BRANCH, 2'h2, 4'h3};
      8'h20, 8'h30: exp_of = '{OP_BIT_BRANCH, 2'h3, 4'h4};
      8'h10: exp_of = '{OP_BIT_TEST_JUMP_CLEAR, 2'h3, 4'h4};
      8'hb5, 8'hb4, 8'hbf, 8'hb6: exp_of = '{OP_COMPARE_BRANCH, 2'h3, 4'h4};
      8'hd8: exp_of = '{OP_DECREMENT_BRANCH, 2'h2, 4'h3};
      8'hd5: exp_of = '{OP_DECREMENT_BRANCH, 2'h3, 4'h4};
      8'hc3, 8'hd3, 8'hb3: exp_of = '{OP_CARRY_BIT_OP, 2'h1, 4'h1};
      8'hc2, 8'hd2, 8'hb2: exp_of = '{OP_DIRECT_BIT_OP, 2'h2, 4'h3};
      8'h82, 8'hb0, 8'h72, 8'ha0: exp_of = '{OP_CARRY_LOGIC, 2'h2, 4'h2};
      8'ha2: exp_of = '{OP_BIT_MOVE, 2'h2, 4'h2};
      8'h92: exp_of = '{OP_BIT_MOVE, 2'h2, 4'h3};
      8'h00: exp_of = '{OP_NOP, 2'h1, 4'h1};
      default: exp_of = '{OP_FOREIGN, 2'h1, 4'h1};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_ret(input int n);
    int k;
    k = 0;
    while (rq.size() < n && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("retire count", n, rq.size());
  endtask
  task automatic send(input logic [7:0] opc);
    cmbd_info_type e;
    e = exp_of(opc);
    rom.put({1'b0, opc});
    if (e.length > 2'h1) rom.put(9'h05a);
    if (e.length > 2'h2) rom.put(9'h0a5);
  endtask
  task automatic check_ret(input int i, input logic [7:0] opc, input logic [3:0] cx);
    cmbd_info_type e;
    e = exp_of(opc);
    chk("opcode", opc, rq[i].opcode);
    chk("op", e.op, rq[i].op);
    chk("length", e.length, rq[i].length);
    chk("cycles", cx, rq[i].cycles);
    chk("operand1", e.length > 2'h1 ? 8'h5a : 8'h00, rq[i].operand1);
    chk("operand2", e.length > 2'h2 ? 8'ha5 : 8'h00, rq[i].operand2);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_table();
    logic [7:0] ops[] = '{8'he8, 8'hef, 8'he5, 8'h74, 8'h7f, 8'hf8, 8'hf5, 8'h88, 8'h85,
      8'h90, 8'h93, 8'h83, 8'hc6, 8'hd7, 8'h11, 8'hf1, 8'h12, 8'h22, 8'h32, 8'he1,
      8'h02, 8'h80, 8'h73, 8'h60, 8'h70, 8'h40, 8'h50, 8'h20, 8'h30, 8'h10, 8'hb5,
      8'hb4, 8'hbf, 8'hb6, 8'hd8, 8'hd5, 8'hc3, 8'hd3, 8'hb3, 8'hc2, 8'hd2, 8'hb2,
      8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92, 8'h00, 8'h28};
    cmbd_info_type e;
    rq.delete();
    rt.delete();
    foreach (ops[i]) send(ops[i]);
    wait_ret(ops.size());
    foreach (ops[i]) begin
      e = exp_of(ops[i]);
      check_ret(i, ops[i], e.cycles);
      if (i > 0) chk("spacing", e.cycles, rt[i] - rt[i-1]);
    end
  endtask
  task automatic test_stall();
    rq.delete();
    rom.put(9'h085);
    rom.put(9'h103);
    rom.put(9'h05a);
    rom.put(9'h102);
    rom.put(9'h0a5);
    wait_ret(1);
    check_ret(0, 8'h85, 4'h4);
  endtask
  task automatic test_xram();
    logic [7:0] opc[6] = '{8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3};
    int k[6] = '{0, 3, 7, 1, 99, 2};
    logic [3:0] base;
    for (int i = 0; i < 6; i++) begin
      rq.delete();
      base = opc[i][4] ? 4'h4 : 4'h3;
      power_ctrl = i[0] ? 8'h10 : 8'hef;
      tgt = base - 2 + k[i];
      send(opc[i]);
      wait_ret(1);
      check_ret(0, opc[i], base + (k[i] > 7 ? 4'h7 : 4'(k[i])));
      chk("code space", i[0], rq[0].code_space);
      chk("xram select", i[0], xram_sel);
    end
    rq.delete();
    send(8'he8);
    wait_ret(1);
    check_ret(0, 8'he8, 4'h1);
  endtask
  task automatic test_reset();
    rq.delete();
    send(8'h12);
    repeat (4) @(posedge clk);
    #1 reset = 1'b1;
    #1;
    chk("ready in reset", 1'b1, code_ready);
    chk("busy in reset", 1'b0, busy);
    chk("retire in reset", 1'b0, retire);
    chk("instr in reset", 64'h0, instr);
    @(posedge clk);
    #1 reset = 1'b0;
    send(8'hef);
    wait_ret(1);
    check_ret(0, 8'hef, 4'h1);
  endtask

  // verdict and end of run
  task automatic complete_run();
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    power_ctrl = 8'hef;
    xram_done = 1'b0;
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    test_table();
    test_stall();
    test_xram();
    test_reset();
    complete_run();
  end
endmodule // cmbd_decoder_bench
